// file: shared/hbg_pkg.sv
package hbg_pkg;

  localparam int unsigned CLK_SYS_HZ  = 25_000_000;
  localparam int unsigned PROC_CLK_HZ = 8_000_000;

  // Register offsets
  localparam logic [3:0] REG_AUDIO   = 4'h0;
  localparam logic [3:0] REG_DSPCTL  = 4'h1;
  localparam logic [3:0] REG_IFSYN   = 4'h2;
  localparam logic [3:0] REG_DAC     = 4'h3;
  localparam logic [3:0] REG_STATUS  = 4'h4;
  localparam logic [3:0] REG_CLEAR   = 4'h5;
  localparam logic [3:0] REG_ENABLE  = 4'h6;
  localparam logic [3:0] REG_BUSSTAT = 4'h7;

  // DSP control latch fields
  localparam int unsigned DSPCTL_RESET_BIT = 0;
  localparam int unsigned DSPCTL_BOOT_BIT  = 1;
  localparam int unsigned DSPCTL_FSK_BIT   = 2;
  // DAC register fields
  localparam int unsigned DAC_SEL_BIT      = 8;

  // Reset values
  localparam logic [5:0] AUDIO_RST  = 6'h00;
  localparam logic [5:0] DSPCTL_RST = 6'h00;
  localparam logic [5:0] IFSYN_RST  = 6'h00;
  localparam logic [4:0] ENABLE_RST = 5'h00;

  // Interrupt source positions, priority order
  localparam int unsigned IRQ_SERIAL = 0;
  localparam int unsigned IRQ_EXPAN  = 1;
  localparam int unsigned IRQ_DSP    = 2;
  localparam int unsigned IRQ_TIMER1 = 3;
  localparam int unsigned IRQ_TIMER2 = 4;

  localparam logic [2:0] FC_IACK = 3'h7;
  localparam int unsigned NUM_SEL = 8;

  // Device access times in ns
  localparam int unsigned PROC_PERIOD_NS = 1_000_000_000 / PROC_CLK_HZ;
  localparam int unsigned ACC_ROM_NS  = 250;
  localparam int unsigned ACC_RAM_NS  = 150;
  localparam int unsigned ACC_PER_NS  = 400;
  localparam int unsigned ACC_DSP_NS  = 200;

  function automatic logic [5:0] cyclesFromNs(input int unsigned ns);
    int unsigned c;
    c = (ns * (CLK_SYS_HZ / 1_000_000) + 999) / 1000;
    if (c < 1) begin
      c = 1;
    end
    return c[5:0];
  endfunction

  // Least acknowledge wait is one processor clock
  localparam logic [5:0] WAIT_MIN = cyclesFromNs(PROC_PERIOD_NS);
  localparam logic [5:0] WAIT_ROM = cyclesFromNs(ACC_ROM_NS);
  localparam logic [5:0] WAIT_RAM = cyclesFromNs(ACC_RAM_NS);
  localparam logic [5:0] WAIT_PER = cyclesFromNs(ACC_PER_NS);
  localparam logic [5:0] WAIT_DSP = cyclesFromNs(ACC_DSP_NS);

  typedef struct packed {
    logic [4:0] region;
    logic [2:0] fc;
    logic       asN;
    logic       udsN;
    logic       ldsN;
    logic       rwN;
    logic       freeRun;
    logic [4:0] irq;
  } hbg_pins_t;

  typedef struct packed {
    logic [5:0] audio;
    logic [5:0] dspCtl;
    logic [5:0] ifSynth;
  } hbg_latch_t;

endpackage

// file: logic/hbg_irq_encoder.sv
`timescale 1ns/100ps
`default_nettype none
module hbg_irq_encoder (
  input  wire logic [4:0] req,
  output logic      [2:0] level
);

  always_comb begin
    level = 3'h0;
    for (int i = 4; i >= 0; i--) begin
      if (req[i]) begin
        level = 3'(i + 1);
      end
    end
  end

endmodule
`default_nettype wire

// file: logic/hbg_transfer_acknowledge_counter.sv
`timescale 1ns/100ps
`default_nettype none
module hbg_transfer_acknowledge_counter (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       clkEn,
  input  wire logic       start,
  input  wire logic [5:0] waitCycles,
  output logic            ackN
);

  typedef enum logic [2:0] {
    HBG_IDLE = 3'b001,
    HBG_WAIT = 3'b010,
    HBG_ACK  = 3'b100
  } hbg_dt_state_t;

  hbg_dt_state_t state_q;
  logic [5:0]    cnt_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= HBG_IDLE;
      cnt_q   <= 6'h00;
      ackN    <= 1'b1;
    end else if (clkEn) begin
      unique case (state_q)
        HBG_IDLE: begin
          ackN  <= 1'b1;
          cnt_q <= 6'h01;
          if (start) begin
            state_q <= HBG_WAIT;
          end
        end
        HBG_WAIT: begin
          if (!start) begin
            state_q <= HBG_IDLE;
          end else if (cnt_q >= waitCycles) begin
            state_q <= HBG_ACK;
            ackN    <= 1'b0;
          end else begin
            cnt_q <= cnt_q + 6'h01;
          end
        end
        HBG_ACK: begin
          if (!start) begin
            state_q <= HBG_IDLE;
            ackN    <= 1'b1;
          end
        end
        default: begin
          state_q <= HBG_IDLE;
          ackN    <= 1'b1;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// file: logic/hbg_glue_top.sv
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module hbg_glue_top (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        clkEn,
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdata,
  input  wire logic [4:0]  procRegion,
  input  wire logic [2:0]  function_code_lines,
  input  wire logic        addrStrobeN,
  input  wire logic        upperStrobeN,
  input  wire logic        lowerStrobeN,
  input  wire logic        readWriteN,
  input  wire logic        free_run_isolate_switch,
  input  wire logic        serialReq,
  input  wire logic        expansionReq,
  input  wire logic        host_request_line,
  input  wire logic        timer1Req,
  input  wire logic        timer2Req,
  output logic      [2:0]  irqLevel,
  output logic      [7:0]  chipSelN,
  output logic             transfer_acknowledge,
  output logic             laneLoEnN,
  output logic             laneHiEnN,
  output logic             laneDirToCpu,
  output logic      [5:0]  audioRoute,
  output logic             dspResetN,
  output logic             boot_mode_select_line,
  output logic             first_keying_port,
  output logic      [5:0]  ifSynthCtl,
  output logic      [7:0]  dacData,
  output logic             dacSelect,
  output logic             dacWriteN,
  output logic             irqOut
);

  hbg_pkg::hbg_pins_t  pinRaw;
  hbg_pkg::hbg_pins_t  pinMeta_q;
  hbg_pkg::hbg_pins_t  pin_q;
  hbg_pkg::hbg_latch_t latch_q;
  logic [4:0]          irqPrev_q;
  logic [4:0]          status_q;
  logic [4:0]          status_d;
  logic [4:0]          enable_q;
  logic [4:0]          irqRise;
  logic [2:0]          levelNext;
  logic [7:0]          selNext;
  logic                cycleActive;
  logic                iackCycle;
  logic [5:0]          waitNext;
  logic [5:0]          wait_q;
  logic                cycleSel;
  logic [15:0]         rdNext;
  logic                wrClear;

  // Selects and wait time from region
  function automatic logic [7:0] selOneHot(input logic [4:0] region);
    logic [7:0] s;
    s = 8'h00;
    if (region[4:3] == 2'h0) begin
      s[region[2:0]] = 1'b1;
    end
    return s;
  endfunction

  function automatic logic [5:0] selWait(input logic [7:0] sel);
    logic [5:0] w;
    w = hbg_pkg::WAIT_MIN;
    if (sel[0]) begin
      w = hbg_pkg::WAIT_ROM;
    end else if (sel[1]) begin
      w = hbg_pkg::WAIT_RAM;
    end else if (sel[6]) begin
      w = hbg_pkg::WAIT_DSP;
    end else if (sel[2] | sel[3] | sel[4] | sel[5] | sel[7]) begin
      w = hbg_pkg::WAIT_PER;
    end
    if (w < hbg_pkg::WAIT_MIN) begin
      w = hbg_pkg::WAIT_MIN;
    end
    return w;
  endfunction

  assign pinRaw.region  = procRegion;
  assign pinRaw.fc      = function_code_lines;
  assign pinRaw.asN     = addrStrobeN;
  assign pinRaw.udsN    = upperStrobeN;
  assign pinRaw.ldsN    = lowerStrobeN;
  assign pinRaw.rwN     = readWriteN;
  assign pinRaw.freeRun = free_run_isolate_switch;
  assign pinRaw.irq     = {timer2Req, timer1Req, host_request_line, expansionReq, serialReq};

  // Two-stage pin synchroniser
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pinMeta_q <= '{region: 5'h00, fc: 3'h0, asN: 1'b1, udsN: 1'b1, ldsN: 1'b1,
                     rwN: 1'b1, freeRun: 1'b0, irq: 5'h00};
      pin_q     <= '{region: 5'h00, fc: 3'h0, asN: 1'b1, udsN: 1'b1, ldsN: 1'b1,
                     rwN: 1'b1, freeRun: 1'b0, irq: 5'h00};
    end else if (clkEn) begin
      pinMeta_q <= pinRaw;
      pin_q     <= pinMeta_q;
    end
  end

  assign iackCycle   = (pin_q.fc == hbg_pkg::FC_IACK);
  assign cycleActive = !pin_q.asN && !iackCycle;
  assign selNext     = cycleActive ? selOneHot(pin_q.region) : 8'h00;
  assign waitNext    = selWait(selNext);
  // Counter follows the select decode so acknowledge drops with the selects
  assign cycleSel    = |selNext;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      chipSelN <= 8'hFF;
      wait_q   <= hbg_pkg::WAIT_MIN;
    end else if (clkEn) begin
      chipSelN <= ~selNext;
      wait_q   <= waitNext;
    end
  end

  hbg_transfer_acknowledge_counter u_transfer_acknowledge (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .clkEn      (clkEn),
    .start      (cycleSel),
    .waitCycles (wait_q),
    .ackN       (transfer_acknowledge)
  );

  // Lane buffer enables
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      laneLoEnN    <= 1'b1;
      laneHiEnN    <= 1'b1;
      laneDirToCpu <= 1'b0;
    end else if (clkEn) begin
      if (pin_q.freeRun) begin
        laneLoEnN <= 1'b1;
        laneHiEnN <= 1'b1;
      end else begin
        laneLoEnN <= !(cycleActive && !pin_q.ldsN);
        laneHiEnN <= !(cycleActive && !pin_q.udsN);
      end
      laneDirToCpu <= pin_q.rwN;
    end
  end

  hbg_irq_encoder u_enc (
    .req   (pin_q.irq),
    .level (levelNext)
  );

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irqLevel <= 3'h0;
    end else if (clkEn) begin
      irqLevel <= levelNext;
    end
  end

  // Sticky status, set wins over clear
  assign irqRise  = pin_q.irq & ~irqPrev_q;
  assign wrClear  = regWr && (regAddr == hbg_pkg::REG_CLEAR);
  assign status_d = (status_q & ~(wrClear ? regWdata[4:0] : 5'h00)) | irqRise;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irqPrev_q <= 5'h00;
      status_q  <= 5'h00;
      irqOut    <= 1'b0;
    end else if (clkEn) begin
      irqPrev_q <= pin_q.irq;
      status_q  <= status_d;
      irqOut    <= |(status_d & enable_q);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      latch_q  <= '{audio: hbg_pkg::AUDIO_RST, dspCtl: hbg_pkg::DSPCTL_RST,
                    ifSynth: hbg_pkg::IFSYN_RST};
      enable_q <= hbg_pkg::ENABLE_RST;
    end else if (clkEn && regWr) begin
      unique case (regAddr)
        hbg_pkg::REG_AUDIO:  latch_q.audio   <= regWdata[5:0];
        hbg_pkg::REG_DSPCTL: latch_q.dspCtl  <= regWdata[5:0];
        hbg_pkg::REG_IFSYN:  latch_q.ifSynth <= regWdata[5:0];
        hbg_pkg::REG_ENABLE: enable_q        <= regWdata[4:0];
        default: ;
      endcase
    end
  end

  // Latch outputs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      audioRoute            <= hbg_pkg::AUDIO_RST;
      ifSynthCtl            <= hbg_pkg::IFSYN_RST;
      dspResetN             <= 1'b0;
      boot_mode_select_line <= 1'b0;
      first_keying_port     <= 1'b0;
    end else if (clkEn) begin
      audioRoute            <= latch_q.audio;
      ifSynthCtl            <= latch_q.ifSynth;
      dspResetN             <= !latch_q.dspCtl[hbg_pkg::DSPCTL_RESET_BIT];
      boot_mode_select_line <= latch_q.dspCtl[hbg_pkg::DSPCTL_BOOT_BIT];
      first_keying_port     <= latch_q.dspCtl[hbg_pkg::DSPCTL_FSK_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dacData   <= 8'h00;
      dacSelect <= 1'b0;
      dacWriteN <= 1'b1;
    end else if (clkEn) begin
      dacWriteN <= 1'b1;
      if (regWr && (regAddr == hbg_pkg::REG_DAC)) begin
        dacData   <= regWdata[7:0];
        dacSelect <= regWdata[hbg_pkg::DAC_SEL_BIT];
        dacWriteN <= 1'b0;
      end
    end
  end

  // Register read mux
  always_comb begin
    rdNext = 16'h0000;
    unique case (regAddr)
      hbg_pkg::REG_AUDIO:   rdNext = {10'h000, latch_q.audio};
      hbg_pkg::REG_DSPCTL:  rdNext = {10'h000, latch_q.dspCtl};
      hbg_pkg::REG_IFSYN:   rdNext = {10'h000, latch_q.ifSynth};
      hbg_pkg::REG_DAC:     rdNext = {7'h00, dacSelect, dacData};
      hbg_pkg::REG_STATUS:  rdNext = {11'h000, status_q};
      hbg_pkg::REG_ENABLE:  rdNext = {11'h000, enable_q};
      hbg_pkg::REG_BUSSTAT: rdNext = {4'h0, pin_q.freeRun, irqLevel, ~chipSelN};
      default:              rdNext = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 16'h0000;
    end else if (clkEn) begin
      regRdata <= regRd ? rdNext : 16'h0000;
    end
  end

endmodule
`default_nettype wire

// file: verif/hbg_glue_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module hbg_glue_monitor (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        clkEn,
  input wire logic [3:0]  regAddr,
  input wire logic [15:0] regWdata,
  input wire logic        regWr,
  input wire logic [2:0]  function_code_lines,
  input wire logic        free_run_isolate_switch,
  input wire logic        serialReq,
  input wire logic        expansionReq,
  input wire logic        host_request_line,
  input wire logic        timer1Req,
  input wire logic        timer2Req,
  input wire logic [2:0]  irqLevel,
  input wire logic [7:0]  chipSelN,
  input wire logic        transfer_acknowledge,
  input wire logic        laneLoEnN,
  input wire logic        laneHiEnN,
  input wire logic        dspResetN,
  input wire logic        boot_mode_select_line,
  input wire logic        dacWriteN
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  logic [4:0] reqV;
  logic [2:0] expLvl;
  assign reqV = {timer2Req, timer1Req, host_request_line, expansionReq, serialReq};
  // Lowest index wins
  always_comb begin
    expLvl = 3'h0;
    for (int i = 4; i >= 0; i--) begin
      if (reqV[i]) begin
        expLvl = 3'(i + 1);
      end
    end
  end
  sequence wrDsp;
    clkEn && regWr && regAddr == hbg_pkg::REG_DSPCTL;
  endsequence
  sequence dacPulse;
    !dacWriteN ##1 dacWriteN;
  endsequence
  sequence selStart;
    $rose(chipSelN != 8'hFF);
  endsequence
  sel_onehot_a: assert property ($onehot0(~chipSelN))
    else $error("more than one select active");
  iack_nosel_a: assert property ((function_code_lines == hbg_pkg::FC_IACK)[*4]
    |-> chipSelN == 8'hFF) else $error("select during interrupt acknowledge");
  ack_after_sel_a: assert property (selStart |-> transfer_acknowledge[*4]
    ##[1:20] !transfer_acknowledge) else $error("acknowledge timing wrong");
  ack_needs_sel_a: assert property (!transfer_acknowledge |-> chipSelN != 8'hFF)
    else $error("acknowledge without select");
  lane_isolate_a: assert property (free_run_isolate_switch[*4]
    |-> laneLoEnN && laneHiEnN) else $error("lane enabled in free run");
  dsp_hold_a: assert property (wrDsp ##0 regWdata[0] |-> ##[1:2] !dspResetN)
    else $error("signal processor reset not held");
  rst_dsp_a: assert property (disable iff (1'b0) !rstn |-> !dspResetN)
    else $error("signal processor reset free in system reset");
  boot_latch_a: assert property (wrDsp ##0 regWdata[1] |-> ##[1:2] boot_mode_select_line)
    else $error("boot line not set");
  dac_pulse_a: assert property (clkEn && regWr && regAddr == hbg_pkg::REG_DAC
    |-> ##[1:2] dacPulse) else $error("converter strobe missing");
  irq_prio_a: assert property ((clkEn && $stable(reqV))[*4] |-> irqLevel == expLvl)
    else $error("interrupt level wrong");
endmodule
bind hbg_glue_top hbg_glue_monitor i_mon (.clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .irqLevel(irqLevel),
  .function_code_lines(function_code_lines), .free_run_isolate_switch(free_run_isolate_switch),
  .serialReq(serialReq), .expansionReq(expansionReq), .host_request_line(host_request_line),
  .timer1Req(timer1Req), .timer2Req(timer2Req), .chipSelN(chipSelN), .dacWriteN(dacWriteN),
  .transfer_acknowledge(transfer_acknowledge), .laneLoEnN(laneLoEnN), .laneHiEnN(laneHiEnN),
  .dspResetN(dspResetN), .boot_mode_select_line(boot_mode_select_line));
`default_nettype wire

// file: verif/hbg_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module hbg_cpu_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] chipSelN,
  input  wire logic       transfer_acknowledge,
  input  wire logic       laneLoEnN,
  input  wire logic       laneHiEnN,
  output logic      [4:0] procRegion,
  output logic      [2:0] function_code_lines,
  output logic            addrStrobeN,
  output logic            upperStrobeN,
  output logic            lowerStrobeN,
  output logic            readWriteN
);
  initial begin
    procRegion = 5'h00;
    function_code_lines = 3'h5;
    addrStrobeN = 1'b1;
    upperStrobeN = 1'b1;
    lowerStrobeN = 1'b1;
    readWriteN = 1'b1;
  end
  task automatic busCycle(input logic [4:0] rg, input logic [2:0] fc, input logic [1:0] strb,
                          output int at, output logic [7:0] sel, output logic [1:0] ln);
    at = -1;
    sel = 8'hFF;
    ln = 2'b11;
    @(posedge clk_sys);
    procRegion <= rg;
    function_code_lines <= fc;
    addrStrobeN <= 1'b0;
    {upperStrobeN, lowerStrobeN} <= strb;
    for (int i = 1; i <= 30 && at < 0; i++) begin
      @(posedge clk_sys);
      if (chipSelN != 8'hFF) begin
        sel = chipSelN;
      end
      if (transfer_acknowledge === 1'b0) begin
        at = i;
        ln = {laneHiEnN, laneLoEnN};
      end
    end
    // Released address lines show no stale value
    addrStrobeN <= 1'b1;
    {upperStrobeN, lowerStrobeN} <= 2'b11;
    procRegion <= ~rg;
    function_code_lines <= 3'h5;
    repeat (6) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// file: verif/hbg_glue_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module hbg_glue_top_tb;
  logic        clk_sys;
  logic        rstn;
  logic        clkEn;
  logic [3:0]  regAddr;
  logic [15:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [15:0] regRdata;
  logic [4:0]  procRegion;
  logic [2:0]  fcLines;
  logic        asN;
  logic        udsN;
  logic        ldsN;
  logic        rwN;
  logic        freeRun;
  logic [4:0]  reqs;
  logic [2:0]  irqLevel;
  logic [7:0]  chipSelN;
  logic        ackN;
  logic        laneLoEnN;
  logic        laneHiEnN;
  logic        laneDir;
  logic [5:0]  audioRoute;
  logic        dspResetN;
  logic        bootLine;
  logic        keyDir;
  logic [5:0]  ifSynthCtl;
  logic [7:0]  dacData;
  logic        dacSelect;
  logic        dacWriteN;
  logic        irqOut;
  int          failures = 0;
  int          checked = 0;
  int          cycles = 0;
  hbg_glue_top i_dut (.clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .procRegion(procRegion), .function_code_lines(fcLines), .addrStrobeN(asN),
    .upperStrobeN(udsN), .lowerStrobeN(ldsN), .readWriteN(rwN),
    .free_run_isolate_switch(freeRun), .serialReq(reqs[0]), .expansionReq(reqs[1]),
    .host_request_line(reqs[2]), .timer1Req(reqs[3]), .timer2Req(reqs[4]),
    .irqLevel(irqLevel), .chipSelN(chipSelN), .transfer_acknowledge(ackN),
    .laneLoEnN(laneLoEnN), .laneHiEnN(laneHiEnN), .laneDirToCpu(laneDir), .audioRoute(audioRoute),
    .dspResetN(dspResetN), .boot_mode_select_line(bootLine), .first_keying_port(keyDir),
    .ifSynthCtl(ifSynthCtl), .dacData(dacData), .dacSelect(dacSelect),
    .dacWriteN(dacWriteN), .irqOut(irqOut));
  hbg_cpu_model i_cpu (.clk_sys(clk_sys), .chipSelN(chipSelN), .transfer_acknowledge(ackN),
    .laneLoEnN(laneLoEnN), .laneHiEnN(laneHiEnN), .procRegion(procRegion),
    .function_code_lines(fcLines), .addrStrobeN(asN), .upperStrobeN(udsN),
    .lowerStrobeN(ldsN), .readWriteN(rwN));
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys);
    d = regRdata;
  endtask
  task automatic testReset;
    logic [15:0] v;
    chk("selects", {8'h00, chipSelN}, 16'h00FF);
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), v);
      chk("reset read", v, 16'h0000);
    end
    $display("reset test done");
  endtask
  task automatic testLatch;
    logic [15:0] v;
    wr(hbg_pkg::REG_AUDIO, 16'hFFEA);
    wr(hbg_pkg::REG_IFSYN, 16'h0015);
    wr(hbg_pkg::REG_DSPCTL, 16'h0007);
    wr(hbg_pkg::REG_STATUS, 16'h001F);
    wr(4'hC, 16'h0033);
    rd(hbg_pkg::REG_AUDIO, v);
    chk("audio read", v, 16'h002A);
    chk("audio pins", {10'h0, audioRoute}, 16'h002A);
    rd(hbg_pkg::REG_IFSYN, v);
    chk("synth read", v, 16'h0015);
    chk("synth pins", {10'h0, ifSynthCtl}, 16'h0015);
    chk("dsp pins", {13'h0, keyDir, bootLine, dspResetN}, 16'h0006);
    rd(hbg_pkg::REG_STATUS, v);
    chk("status read", v, 16'h0000);
    @(posedge clk_sys);
    clkEn <= 1'b0;
    wr(hbg_pkg::REG_DSPCTL, 16'h0000);
    clkEn <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("frozen dsp pins", {13'h0, keyDir, bootLine, dspResetN}, 16'h0006);
    wr(hbg_pkg::REG_DSPCTL, 16'h0002);
    repeat (3) @(negedge clk_sys);
    chk("boot high", {13'h0, keyDir, bootLine, dspResetN}, 16'h0003);
    $display("latch test done");
  endtask
  task automatic testDac;
    int n;
    n = 0;
    wr(hbg_pkg::REG_DAC, 16'h01A5);
    repeat (3) begin
      @(negedge clk_sys);
      n += (dacWriteN === 1'b0) ? 1 : 0;
    end
    chk("dac strobe count", 16'(n), 16'h0001);
    chk("dac lines", {7'h0, dacSelect, dacData}, 16'h01A5);
    $display("converter test done");
  endtask
  task automatic testBus;
    int at;
    int w;
    logic [7:0] sel;
    logic [1:0] ln;
    for (int r = 0; r < 10; r++) begin
      w = (r == 0) ? hbg_pkg::WAIT_ROM : (r == 1) ? hbg_pkg::WAIT_RAM :
          (r == 6) ? hbg_pkg::WAIT_DSP : hbg_pkg::WAIT_PER;
      i_cpu.busCycle((r == 9) ? 5'h10 : 5'(r), 3'h5, 2'b00, at, sel, ln);
      chk("select", {8'h0, sel}, (r < 8) ? {8'h0, ~(8'h01 << r)} : 16'h00FF);
      chk("ack wait", 16'((r < 8) ? (at >= w + 3 && at <= w + 7) : (at < 0)), 16'h0001);
      chk("lanes", {14'h0, ln}, (r < 8) ? 16'h0000 : 16'h0003);
    end
    chk("lane dir", {15'h0, laneDir}, 16'h0001);
    i_cpu.busCycle(5'h00, hbg_pkg::FC_IACK, 2'b00, at, sel, ln);
    chk("iack select", {8'h0, sel}, 16'h00FF);
    chk("iack ack", 16'(at < 0), 16'h0001);
    i_cpu.busCycle(5'h01, 3'h5, 2'b10, at, sel, ln);
    chk("lower lane only", {14'h0, ln}, 16'h0002);
    @(posedge clk_sys);
    freeRun <= 1'b1;
    i_cpu.busCycle(5'h01, 3'h5, 2'b00, at, sel, ln);
    chk("isolated lanes", {14'h0, ln}, 16'h0003);
    chk("isolated select", {8'h0, sel}, 16'h00FD);
    freeRun <= 1'b0;
    $display("bus test done");
  endtask
  task automatic testIrq;
    logic [15:0] v;
    for (int i = 4; i >= 0; i--) begin
      @(posedge clk_sys);
      reqs[i] <= 1'b1;
      repeat (6) @(negedge clk_sys);
      chk("level", {13'h0, irqLevel}, 16'(i + 1));
    end
    chk("masked irq", {15'h0, irqOut}, 16'h0000);
    rd(hbg_pkg::REG_STATUS, v);
    chk("status", v, 16'h001F);
    wr(hbg_pkg::REG_ENABLE, 16'h0004);
    repeat (3) @(negedge clk_sys);
    chk("host irq", {15'h0, irqOut}, 16'h0001);
    wr(hbg_pkg::REG_CLEAR, 16'h0004);
    repeat (3) @(negedge clk_sys);
    chk("cleared irq", {15'h0, irqOut}, 16'h0000);
    rd(hbg_pkg::REG_STATUS, v);
    chk("status after clear", v, 16'h001B);
    @(posedge clk_sys);
    reqs <= 5'h00;
    repeat (6) @(negedge clk_sys);
    chk("idle level", {13'h0, irqLevel}, 16'h0000);
    $display("interrupt test done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      test_done;
    end
  end
  initial begin
    rstn <= 1'b0;
    clkEn = 1'b1;
    regAddr = 4'h0;
    regWdata = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    freeRun = 1'b0;
    reqs = 5'h00;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    testReset;
    testLatch;
    testDac;
    testBus;
    testIrq;
    test_done;
  end
endmodule
`default_nettype wire
